// [conv_ctrl.sv]
// Converter control: APB registers, triggers, sequencing of conversions.
// Assumes an APB master on CORE_CLK and an analog core driven by pins.
// What this block does
// - Converter-on bit 0 clear powers down and stops; set powers up, converts.
// - Bit 1 clear gives a single regular sequence; set keeps converting without triggers.
// - With DMA bit 8, bit 9 picks requests stopping after last or always.
// - Bit 11 selects right-aligned results at 0, left-aligned at 1.
// - Bits 19:16 pick one of sixteen injected sources, 1111 is line 15.
// - Bits 21:20 injected edge: off, rising, falling, both.
// - Writing 1 to bit 22 starts the injected group; resets to 0.
// - Bits 27:24 pick one of sixteen regular sources, 1111 is line 15.
// - Bits 29:28 regular edge: off, rising, falling, both.
// - Writing 1 to bit 30 starts the regular group; resets to 0.
// - Sample code 000..111 gives 3,15,28,56,84,112,144,480 cycles.
// - Sample codes packed in 3-bit fields; upper uses 26:0, lower 29:0.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int REG_SEQ_LEN = 1,  // Conversions per regular sequence
    parameter int INJ_SEQ_LEN = 1   // Conversions per injected sequence
)(
    input  wire logic        CORE_CLK,          // 25 MHz core clock
    input  wire logic        RST_B,             // Async reset, active low
    input  wire logic        PSEL,              // APB select
    input  wire logic        PENABLE,           // APB access phase
    input  wire logic        PWRITE,            // APB direction
    input  wire logic [11:0] PADDR,             // APB byte address
    input  wire logic [31:0] PWDATA,            // APB write data
    output logic      [31:0] PRDATA,            // APB read data
    output logic             PREADY,            // APB ready
    output logic             PSLVERR,           // APB error
    input  wire logic [15:0] REG_EVENTS,        // Regular trigger sources
    input  wire logic [15:0] INJ_EVENTS,        // Injected trigger sources
    input  wire logic [4:0]  REG_CHANNEL,       // Regular channel to convert
    input  wire logic [4:0]  INJ_CHANNEL,       // Injected channel to convert
    input  wire logic        DMA_LAST,          // DMA reached final transfer
    output logic             POWER_DOWN,        // Analog core powered down
    output logic             SAMPLING,          // Sample switch closed
    output logic [4:0]       CONV_CHANNEL,      // Channel being converted
    output logic             CONV_INJECTED,     // Current is injected group
    output logic             RESULT_LEFT,       // Left-aligned results
    output logic             REGULAR_DONE_FLAG, // Regular done pulse
    output logic             INJECTED_DONE,     // Injected sequence done
    output logic             DMA_REQUEST        // DMA request pulse
);
    typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} conv_state_e;

    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] smp_up_reg, smp_up_next;
    logic [31:0] smp_lo_reg, smp_lo_next;
    control_s    cfg;
    logic        wr_en, rd_en, addr_ok;

    conv_state_e state_reg, state_next;
    logic [SAMPLE_CNT_W-1:0] cnt_reg, cnt_next;
    logic [4:0]  idx_reg, idx_next;
    logic        inj_reg, inj_next;
    logic        reg_pend_reg, reg_pend_next;
    logic        inj_pend_reg, inj_pend_next;
    logic        dma_stop_reg, dma_stop_next;
    logic [4:0]  chan_reg, chan_next;
    logic        rdone_reg, rdone_next;
    logic        idone_reg, idone_next;
    logic        dreq_reg, dreq_next;
    logic        reg_fire, inj_fire;
    logic [2:0]  smp_code;
    logic [4:0]  cur_chan;
    logic        last_conv;

    assign cfg.converter_on            = ctrl_reg[BIT_CONVERTER_ON];
    assign cfg.repeat_conversion       = ctrl_reg[BIT_REPEAT_CONVERSION];
    assign cfg.dma_mode_on             = ctrl_reg[BIT_DMA_MODE_ON];
    assign cfg.dma_request_policy      = ctrl_reg[BIT_DMA_REQUEST_POLICY];
    assign cfg.done_flag_timing        = ctrl_reg[BIT_DONE_FLAG_TIMING];
    assign cfg.result_alignment        = ctrl_reg[BIT_RESULT_ALIGNMENT];
    assign cfg.injected_trigger_source = ctrl_reg[LSB_INJ_SOURCE +: 4];
    assign cfg.injected_trigger_edge   = ctrl_reg[LSB_INJ_EDGE +: 2];
    assign cfg.regular_trigger_source  = ctrl_reg[LSB_REG_SOURCE +: 4];
    assign cfg.regular_trigger_edge    = ctrl_reg[LSB_REG_EDGE +: 2];

    trigger_edge_detect u_reg_trig (
        .clk      (CORE_CLK),
        .rst_b    (RST_B),
        .events   (REG_EVENTS),
        .source   (cfg.regular_trigger_source),
        .edge_sel (cfg.regular_trigger_edge),
        .fire     (reg_fire)
    );

    trigger_edge_detect u_inj_trig (
        .clk      (CORE_CLK),
        .rst_b    (RST_B),
        .events   (INJ_EVENTS),
        .source   (cfg.injected_trigger_source),
        .edge_sel (cfg.injected_trigger_edge),
        .fire     (inj_fire)
    );

    // Zero-wait APB slave; unmapped addresses answer with an error
    always_comb begin
        addr_ok = (PADDR == OFS_CONTROL_TWO) || (PADDR == OFS_SAMPLE_UPPER)
               || (PADDR == OFS_SAMPLE_LOWER) || (PADDR == OFS_RUN_STATUS);
        wr_en   = PSEL & PENABLE & PWRITE;
        rd_en   = PSEL & PENABLE & ~PWRITE;
        PREADY  = 1'b1;
        PSLVERR = PSEL & PENABLE & ~addr_ok;
    end

    // Sample code lookup by channel
    always_comb begin
        cur_chan = inj_reg ? INJ_CHANNEL : REG_CHANNEL;
        if (cur_chan < 5'(LOWER_CHANNELS)) begin
            smp_code = smp_lo_reg[cur_chan*3 +: 3];
        end else if (cur_chan < 5'(CHANNELS)) begin
            smp_code = smp_up_reg[(cur_chan - 5'(LOWER_CHANNELS))*3 +: 3];
        end else begin
            smp_code = 3'h0;
        end
    end

    always_comb begin
        ctrl_next   = ctrl_reg;
        smp_up_next = smp_up_reg;
        smp_lo_next = smp_lo_reg;
        if (wr_en && PADDR == OFS_CONTROL_TWO) begin
            ctrl_next = PWDATA & CONTROL_TWO_MASK;
        end
        if (wr_en && PADDR == OFS_SAMPLE_UPPER) begin
            smp_up_next = PWDATA & SAMPLE_UPPER_MASK;
        end
        if (wr_en && PADDR == OFS_SAMPLE_LOWER) begin
            smp_lo_next = PWDATA & SAMPLE_LOWER_MASK;
        end
        // Start bits are write-one pulses; they never hold a value
        ctrl_next[BIT_INJ_SOFT_START] = 1'b0;
        ctrl_next[BIT_REG_SOFT_START] = 1'b0;
    end

    always_comb begin
        unique case (PADDR)
            OFS_CONTROL_TWO:  PRDATA = ctrl_reg;
            OFS_SAMPLE_UPPER: PRDATA = smp_up_reg;
            OFS_SAMPLE_LOWER: PRDATA = smp_lo_reg;
            OFS_RUN_STATUS:   PRDATA = {26'h0000000, reg_pend_reg,
                                        inj_pend_reg, dma_stop_reg,
                                        inj_reg, state_reg};
            default:          PRDATA = 32'h00000000;
        endcase
        if (!rd_en) begin
            PRDATA = 32'h00000000;
        end
    end

    // Conversion sequencer; injected requests win over regular ones in IDLE, which continuous regular runs never reach
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        idx_next      = idx_reg;
        inj_next      = inj_reg;
        chan_next     = chan_reg;
        reg_pend_next = reg_pend_reg;
        inj_pend_next = inj_pend_reg;
        dma_stop_next = dma_stop_reg;
        rdone_next    = 1'b0;
        idone_next    = 1'b0;
        dreq_next     = 1'b0;
        last_conv     = inj_reg ? (idx_reg == 5'(INJ_SEQ_LEN - 1))
                                : (idx_reg == 5'(REG_SEQ_LEN - 1));
        if (reg_fire || (wr_en && PADDR == OFS_CONTROL_TWO
                && PWDATA[BIT_REG_SOFT_START])) begin
            reg_pend_next = 1'b1;
        end
        if (inj_fire || (wr_en && PADDR == OFS_CONTROL_TWO
                && PWDATA[BIT_INJ_SOFT_START])) begin
            inj_pend_next = 1'b1;
        end
        if (DMA_LAST) begin
            dma_stop_next = 1'b1;
        end
        if (!cfg.dma_mode_on) begin
            dma_stop_next = 1'b0;
        end
        unique case (state_reg)
            IDLE: begin
                if (inj_pend_reg) begin
                    inj_pend_next = 1'b0;
                    inj_next      = 1'b1;
                    idx_next      = 5'h00;
                    state_next    = SAMPLE;
                    cnt_next      = 9'h000;
                end else if (reg_pend_reg) begin
                    reg_pend_next = 1'b0;
                    inj_next      = 1'b0;
                    idx_next      = 5'h00;
                    state_next    = SAMPLE;
                    cnt_next      = 9'h000;
                end
            end
            SAMPLE: begin
                chan_next = cur_chan;
                if (cnt_reg >= SAMPLE_LEN[smp_code] - 9'd1) begin
                    state_next = CONVERT;
                    cnt_next   = 9'h000;
                end else begin
                    cnt_next = cnt_reg + 9'd1;
                end
            end
            CONVERT: begin
                if (cnt_reg >= 9'(CONVERT_CYCLES - 1)) begin
                    cnt_next   = 9'h000;
                    state_next = last_conv ? IDLE : SAMPLE;
                    idx_next   = last_conv ? 5'h00 : idx_reg + 5'h01;
                    if (inj_reg) begin
                        idone_next = last_conv;
                    end else begin
                        rdone_next = cfg.done_flag_timing | last_conv;
                        dreq_next  = cfg.dma_mode_on
                                   & (cfg.dma_request_policy | ~dma_stop_reg);
                        if (last_conv && cfg.repeat_conversion) begin
                            state_next = SAMPLE;
                        end
                    end
                end else begin
                    cnt_next = cnt_reg + 9'd1;
                end
            end
        endcase
        if (!cfg.converter_on) begin
            state_next    = IDLE;
            cnt_next      = 9'h000;
            idx_next      = 5'h00;
            reg_pend_next = 1'b0;
            inj_pend_next = 1'b0;
        end else if (state_reg == IDLE && !ctrl_reg[BIT_CONVERTER_ON]) begin
            state_next = IDLE;
        end
        if (wr_en && PADDR == OFS_CONTROL_TWO
                && PWDATA[BIT_CONVERTER_ON] && !cfg.converter_on) begin
            reg_pend_next = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_reg     <= CONTROL_TWO_RESET;
            smp_up_reg   <= SAMPLE_RESET;
            smp_lo_reg   <= SAMPLE_RESET;
            state_reg    <= IDLE;
            cnt_reg      <= 9'h000;
            idx_reg      <= 5'h00;
            inj_reg      <= 1'b0;
            chan_reg     <= 5'h00;
            reg_pend_reg <= 1'b0;
            inj_pend_reg <= 1'b0;
            dma_stop_reg <= 1'b0;
            rdone_reg    <= 1'b0;
            idone_reg    <= 1'b0;
            dreq_reg     <= 1'b0;
        end else begin
            ctrl_reg     <= ctrl_next;
            smp_up_reg   <= smp_up_next;
            smp_lo_reg   <= smp_lo_next;
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            idx_reg      <= idx_next;
            inj_reg      <= inj_next;
            chan_reg     <= chan_next;
            reg_pend_reg <= reg_pend_next;
            inj_pend_reg <= inj_pend_next;
            dma_stop_reg <= dma_stop_next;
            rdone_reg    <= rdone_next;
            idone_reg    <= idone_next;
            dreq_reg     <= dreq_next;
        end
    end

    assign POWER_DOWN        = ~cfg.converter_on;
    assign SAMPLING          = (state_reg == SAMPLE);
    assign CONV_CHANNEL      = chan_reg;
    assign CONV_INJECTED     = inj_reg;
    assign RESULT_LEFT       = cfg.result_alignment;
    assign REGULAR_DONE_FLAG = rdone_reg;
    assign INJECTED_DONE     = idone_reg;
    assign DMA_REQUEST       = dreq_reg;
endmodule
`default_nettype wire

// [conv_ctrl_chk.sv]
// Concurrent checks on the converter control block's ports.
// Assumes it is bound to conv_ctrl and sees only its top-level ports.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_chk
    import conv_ctrl_pkg::*;
(
    input wire logic        CORE_CLK,          // Core clock
    input wire logic        RST_B,             // Async reset, active low
    input wire logic        PSEL,              // APB select
    input wire logic        PENABLE,           // APB access phase
    input wire logic        PWRITE,            // APB direction
    input wire logic [11:0] PADDR,             // APB address
    input wire logic [31:0] PWDATA,            // APB write data
    input wire logic [31:0] PRDATA,            // APB read data
    input wire logic        PREADY,            // APB ready
    input wire logic        PSLVERR,           // APB error
    input wire logic        POWER_DOWN,        // Analog powered down
    input wire logic        SAMPLING,          // Sample switch closed
    input wire logic        RESULT_LEFT,       // Left alignment
    input wire logic        REGULAR_DONE_FLAG, // Regular done pulse
    input wire logic        INJECTED_DONE,     // Injected done pulse
    input wire logic        DMA_REQUEST        // DMA request pulse
);
    logic acc;
    logic mapped;
    logic ctl_wr;
    assign acc = PSEL && PENABLE;
    assign mapped = PADDR inside {OFS_CONTROL_TWO, OFS_SAMPLE_UPPER,
                                  OFS_SAMPLE_LOWER, OFS_RUN_STATUS};
    assign ctl_wr = acc && PWRITE && (PADDR == OFS_CONTROL_TWO);

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    // One cycle of slack: state may clear an edge after power-down
    chk_off_no_sample: assert property (POWER_DOWN && $past(POWER_DOWN) |-> !SAMPLING) else $error("sampling while powered down");
    chk_on_follows: assert property (ctl_wr |=> POWER_DOWN == !$past(PWDATA[0])) else $error("power state not from write");
    chk_align_write: assert property (ctl_wr |=> RESULT_LEFT == $past(PWDATA[11])) else $error("alignment not from write");
    chk_ready_zero_wait: assert property (acc |-> PREADY) else $error("wait state inserted");
    chk_err_unmapped: assert property (acc |-> PSLVERR == !mapped) else $error("error response wrong");
    chk_rdata_quiet: assert property (!acc || !mapped |-> PRDATA == 32'h0) else $error("read data outside access");
    chk_done_pulse: assert property (REGULAR_DONE_FLAG |=> !REGULAR_DONE_FLAG) else $error("done flag longer than a cycle");
    chk_dma_pulse: assert property (DMA_REQUEST |=> !DMA_REQUEST) else $error("dma request longer than a cycle");
    chk_dma_off: assert property (ctl_wr && !PWDATA[8] |-> ##2 (!DMA_REQUEST) [*8]) else $error("dma request with dma off");
    chk_convert_gap: assert property ($fell(SAMPLING) && !POWER_DOWN |-> (!SAMPLING) [*8]) else $error("sample restarted during convert");

    cover property (REGULAR_DONE_FLAG);
    cover property (INJECTED_DONE);
    cover property (DMA_REQUEST);
    cover property (acc && PSLVERR);
endmodule
`default_nettype wire

// [conv_ctrl_pkg.sv]
// Shared constants and carriers for the converter control block.
// Assumes a 32-bit APB register port and one 25 MHz core clock.
package conv_ctrl_pkg;

    localparam logic [11:0] OFS_CONTROL_TWO = 12'h008;
    localparam logic [11:0] OFS_SAMPLE_UPPER = 12'h00C;
    localparam logic [11:0] OFS_SAMPLE_LOWER = 12'h010;
    localparam logic [11:0] OFS_RUN_STATUS = 12'h014;

    localparam int BIT_CONVERTER_ON = 0;
    localparam int BIT_REPEAT_CONVERSION = 1;
    localparam int BIT_DMA_MODE_ON = 8;
    localparam int BIT_DMA_REQUEST_POLICY = 9;
    localparam int BIT_DONE_FLAG_TIMING = 10;
    localparam int BIT_RESULT_ALIGNMENT = 11;
    localparam int LSB_INJ_SOURCE = 16;
    localparam int LSB_INJ_EDGE = 20;
    localparam int BIT_INJ_SOFT_START = 22;
    localparam int LSB_REG_SOURCE = 24;
    localparam int LSB_REG_EDGE = 28;
    localparam int BIT_REG_SOFT_START = 30;

    localparam logic [31:0] CONTROL_TWO_MASK = 32'h7F7F0F03;
    localparam logic [31:0] SAMPLE_UPPER_MASK = 32'h07FFFFFF;
    localparam logic [31:0] SAMPLE_LOWER_MASK = 32'h3FFFFFFF;
    localparam logic [31:0] CONTROL_TWO_RESET = 32'h00000000;
    localparam logic [31:0] SAMPLE_RESET = 32'h00000000;

    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    localparam int CHANNELS = 19;
    localparam int LOWER_CHANNELS = 10;
    localparam int SAMPLE_CODE_W = 3;
    localparam int SAMPLE_CNT_W = 9;
    localparam int CONVERT_CYCLES = 12;

    typedef logic [SAMPLE_CNT_W-1:0] sample_len_t;
    localparam sample_len_t SAMPLE_LEN [8] = '{
        9'd3, 9'd15, 9'd28, 9'd56, 9'd84, 9'd112, 9'd144, 9'd480
    };

    typedef struct packed {
        logic       converter_on;
        logic       repeat_conversion;
        logic       dma_mode_on;
        logic       dma_request_policy;
        logic       done_flag_timing;
        logic       result_alignment;
        logic [3:0] injected_trigger_source;
        logic [1:0] injected_trigger_edge;
        logic [3:0] regular_trigger_source;
        logic [1:0] regular_trigger_edge;
    } control_s;

    typedef struct packed {
        logic [4:0] channel;
        logic       last_in_sequence;
    } conv_req_s;

endpackage

// [tb.sv]
// Self-checking bench for the converter control block.
// Assumes conv_ctrl and its checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import conv_ctrl_pkg::*;
    localparam int REG_SEQ = 2;
    localparam logic [11:0] RA [3] = '{12'h008, 12'h00C, 12'h010};
    localparam logic [31:0] RM [3] = '{32'h3F3F0F03, 32'h07FFFFFF,
                                       32'h3FFFFFFF};
    localparam int LEN [8] = '{3, 15, 28, 56, 84, 112, 144, 480};
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] reg_ev = 16'h0;
    logic [15:0] inj_ev = 16'h0;
    logic [4:0]  reg_ch = 5'h0;
    logic [4:0]  inj_ch = 5'h5;
    logic        dma_last = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        power_down;
    logic        sampling;
    logic [4:0]  conv_ch;
    logic        conv_inj;
    logic        result_left;
    logic        rdone;
    logic        idone;
    logic        dmareq;
    logic [31:0] rq;
    logic        re;
    int          errors = 0;
    int          checks_done = 0;
    int          n_smp;
    int          n_rd;
    int          n_id;
    int          n_dma;

    always #20 clk = ~clk;

    conv_ctrl #(.REG_SEQ_LEN(REG_SEQ), .INJ_SEQ_LEN(1)) i_conv_ctrl (
        .CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .REG_EVENTS(reg_ev),
        .INJ_EVENTS(inj_ev), .REG_CHANNEL(reg_ch), .INJ_CHANNEL(inj_ch),
        .DMA_LAST(dma_last), .POWER_DOWN(power_down), .SAMPLING(sampling),
        .CONV_CHANNEL(conv_ch), .CONV_INJECTED(conv_inj),
        .RESULT_LEFT(result_left), .REGULAR_DONE_FLAG(rdone),
        .INJECTED_DONE(idone), .DMA_REQUEST(dmareq));

    task automatic conclude();
        $display("errors=%0d checks=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until PREADY is seen high at a rising edge, or for at most 50 edges
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic watch(input int n);
        logic prev;
        prev = sampling;
        n_smp = 0;
        n_rd = 0;
        n_id = 0;
        n_dma = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            n_smp += int'(sampling === 1'b1 && prev !== 1'b1);
            prev = sampling;
            n_rd += int'(rdone === 1'b1);
            n_id += int'(idone === 1'b1);
            n_dma += int'(dmareq === 1'b1);
        end
    endtask

    task automatic t_regs();
        chk32(32'(power_down), 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, RA[i], 32'h0);
            chk32(rq, 32'h0);
            apb(1'b1, RA[i], 32'hFFFFFFFF);
            apb(1'b0, RA[i], 32'h0);
            chk32(rq, RM[i]);
        end
        chk32(32'(result_left), 32'h1);
        apb(1'b1, 12'h008, 32'h0);
        #1;
        chk32(32'(result_left), 32'h0);
        apb(1'b1, 12'h004, 32'hFFFFFFFF);
        chk32(32'(re), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk32(rq, 32'h0);
        apb(1'b1, 12'h00C, 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        watch(40);
        chk32(32'(n_smp), 32'h0);
    endtask

    // Even codes on lower-register channel 3, odd on upper channel 12
    task automatic t_sample();
        logic [4:0]  ch;
        logic [11:0] adr;
        int          cnt;
        for (int c = 0; c < 8; c++) begin
            ch = (c % 2 == 0) ? 5'd3 : 5'd12;
            adr = (c % 2 == 0) ? 12'h010 : 12'h00C;
            reg_ch <= ch;
            apb(1'b1, adr, 32'(c) << ((c % 2 == 0) ? 9 : 6));
            apb(1'b1, 12'h008, 32'h1);
            #1;
            for (int n = 0; n < 40 && sampling !== 1'b1; n++) begin
                @(posedge clk);
                #1;
            end
            chk32(32'(power_down), 32'h0);
            cnt = 0;
            while (sampling === 1'b1 && cnt < 600) begin
                cnt++;
                @(posedge clk);
                #1;
            end
            // Channel register follows the first sample cycle
            chk32(32'(conv_ch), 32'(ch));
            chk32(32'(cnt), 32'(LEN[c]));
            apb(1'b1, 12'h008, 32'h0);
            apb(1'b1, adr, 32'h0);
        end
    endtask

    task automatic t_seq(input logic tim);
        apb(1'b1, 12'h008, 32'h1 | (32'(tim) << 10));
        watch(100);
        chk32(32'(n_smp), 32'(REG_SEQ));
        chk32(32'(n_rd), tim ? 32'(REG_SEQ) : 32'h1);
        apb(1'b1, 12'h008, 32'h40000001 | (32'(tim) << 10));
        watch(100);
        chk32(32'(n_smp), 32'(REG_SEQ));
        apb(1'b0, 12'h008, 32'h0);
        chk32(rq, 32'h1 | (32'(tim) << 10));
        apb(1'b1, 12'h008, 32'h00400001);
        watch(100);
        chk32({n_smp[7:0], n_id[7:0], n_rd[7:0]}, 32'h010100);
        apb(1'b1, 12'h008, 32'h0);
    endtask

    task automatic t_dma();
        apb(1'b1, 12'h008, 32'h00000703);
        watch(200);
        chk32(32'(n_smp > 5), 32'h1);
        chk32(32'(n_dma - n_smp + 1 inside {[0:2]}), 32'h1);
        apb(1'b1, 12'h008, 32'h00000503);
        dma_last <= 1'b1;
        @(posedge clk);
        dma_last <= 1'b0;
        watch(20);
        watch(200);
        chk32(32'(n_dma), 32'h0);
        apb(1'b1, 12'h008, 32'h00000403);
        apb(1'b1, 12'h008, 32'h00000503);
        watch(100);
        chk32(32'(n_dma > 2), 32'h1);
        apb(1'b1, 12'h008, 32'h0);
    endtask

    task automatic t_trig(input logic inj);
        logic [1:0]  e;
        logic [31:0] cfg;
        logic [15:0] v [4];
        for (int s = 0; s < 16; s++) begin
            e = 2'(s);
            cfg = inj ? (32'(s) << 16) | (32'(e) << 20)
                      : (32'(s) << 24) | (32'(e) << 28);
            v = '{~(16'h1 << s), 16'h0, 16'h1 << s, 16'h0};
            apb(1'b1, 12'h008, 32'h1 | cfg);
            watch(60);
            for (int k = 0; k < 4; k++) begin
                if (inj) inj_ev <= v[k];
                else reg_ev <= v[k];
                watch(60);
                chk32(32'(inj ? n_id : n_rd), (k == 2) ? 32'(e[0]) : (k == 3) ? 32'(e[1]) : 32'h0);
            end
        end
        apb(1'b1, 12'h008, 32'h0);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_sample();
        t_seq(1'b0);
        t_seq(1'b1);
        t_dma();
        t_trig(1'b0);
        t_trig(1'b1);
        conclude();
    end

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        conclude();
    end
endmodule

bind conv_ctrl conv_ctrl_chk i_conv_ctrl_chk (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .POWER_DOWN(POWER_DOWN),
    .SAMPLING(SAMPLING), .RESULT_LEFT(RESULT_LEFT),
    .REGULAR_DONE_FLAG(REGULAR_DONE_FLAG), .INJECTED_DONE(INJECTED_DONE),
    .DMA_REQUEST(DMA_REQUEST));
`default_nettype wire

// [trigger_edge_detect.sv]
// Selects one of sixteen trigger events and detects the chosen edge.
// Assumes event inputs come from outside; they pass two flip-flops here.
`timescale 1ns/1ps
`default_nettype none
module trigger_edge_detect
    import conv_ctrl_pkg::*;
(
    input  wire logic        clk,      // Core clock
    input  wire logic        rst_b,    // Async reset, active low
    input  wire logic [15:0] events,   // Raw trigger sources
    input  wire logic [3:0]  source,   // Selected source
    input  wire logic [1:0]  edge_sel, // Edge detection mode
    output logic             fire      // One-cycle start pulse
);
    logic [15:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
    logic        prev_reg, prev_next;
    logic        level;

    always_comb begin
        sync1_next = events;
        sync2_next = sync1_reg;
        level      = sync2_reg[source];
        prev_next  = level;
        unique case (edge_sel)
            EDGE_OFF:  fire = 1'b0;
            EDGE_RISE: fire = level & ~prev_reg;
            EDGE_FALL: fire = ~level & prev_reg;
            EDGE_BOTH: fire = level ^ prev_reg;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg  <= prev_next;
        end
    end
endmodule
`default_nettype wire
